// >>> logic/aic_io_ctrl.sv
/*
 * aic_io_ctrl: additive injector i/o control with classic wishbone slave.
 * permissive and interlock, alarm reset, clean-arm and slow-flow, pump
 * feedback supervision, external solenoid, tank switches, alarm and block
 * valve outputs, injector feedback.
 * assumes: all inputs synchronous to ref_clk_i; injection events arrive as
 * one-cycle pulses from the injection sequencer outside this block.
 */
// Added by the designer: the address map and the Wishbone register port.
// Summary of operation
// - with interlock, combine permissive by or/and
// - no interlock: permissive alone enables
// - alarms cleared by hardwired, serial, panel reset
// - clean-arm needs count, low-flow source, smart
// - first n injections get flush/n extra
// - slow-flow during clean-arm stops injecting
// - flush alarm if post-slow volume mismatches
// - slow-flow from pulse rate, discrete or serial
// - pump feedback missing past timeout raises alarm
// - external solenoid held open until close
// - tank low alarms, self clearing, keeps running
// - tank empty blocks operation, self clearing
// - display action: alarm indication on
// - shutdown action: shutdown, stop, refuse starts
// - block valve follows permissive
// - fixed pulses use configured duration
// - piston switch follows solenoid, inverted variant
// - post injection pulse when solenoid closes
// - double pulse at 25/75 %, last at 75 %
// - extended piston adds one pulse duration
// - end sensor toggles after flow and 25 %
// - mid stroke pulse at 50 %
// - transaction runs while permissive true
// - pulse duration in ms, 0 to 1000, 500

`timescale 1ns/1ps
`default_nettype none
module aic_io_ctrl #(
  parameter int unsigned TICK_CYCLES = aic_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // field inputs
  input wire logic permissive_i,
  input wire logic interlock_i,
  input wire logic alarm_reset_i,
  input wire logic pump_demand_i,
  input wire logic pump_fb_i,
  input wire logic tank_low_i,
  input wire logic tank_empty_i,
  input wire logic slow_flow_di_i,
  input wire logic [15:0] flow_rate_i,
  input wire logic ws_pulse_i,
  input wire logic sol_di_i,
  input wire logic sol_ai_i,
  // injection sequencer events
  input wire logic inj_start_i,
  input wire logic sol_active_i,
  input wire logic dose25_i,
  input wire logic dose50_i,
  input wire logic dose75_i,
  input wire logic add_flow_i,
  // outputs
  output logic enable_o,
  output logic inject_hold_o,
  output logic [15:0] extra_qty_o,
  output logic ext_sol_o,
  output logic alarm_ind_o,
  output logic shutdown_o,
  output logic block_valve_o,
  output logic feedback_o
);
  if (TICK_CYCLES < 2) begin : g_chk
    $error("aic_io_ctrl: TICK_CYCLES too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and bus
  logic [12:0] ctrl_q;
  logic [3:0] fb_mode_q;
  logic [9:0] fb_dur_q;
  logic [7:0] flush_n_q;
  logic [15:0] flush_vol_q;
  logic [15:0] slow_thr_q;
  logic [15:0] pump_to_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr;
  logic [5:0] cmd;
  logic [31:0] status;
  logic [9:0] dur_wr;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign cmd = (wr && wb_adr_i == aic_pkg::OFS_CMD && wb_sel_i[0])
               ? wb_dat_i[5:0] : 6'h00;
  assign dur_wr = (wb_dat_i[aic_pkg::FB_DUR_LSB +: 10] > aic_pkg::FB_DUR_MAX)
                  ? aic_pkg::FB_DUR_MAX
                  : wb_dat_i[aic_pkg::FB_DUR_LSB +: 10];

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= aic_pkg::CTRL_RESET;
      fb_mode_q <= aic_pkg::FBM_NONE;
      fb_dur_q <= aic_pkg::FB_DUR_RESET;
      flush_n_q <= 8'h00;
      flush_vol_q <= 16'h0000;
      slow_thr_q <= aic_pkg::SLOW_THR_RESET;
      pump_to_q <= aic_pkg::PUMP_TO_RESET;
    end else if (wr) begin
      case (wb_adr_i)
        aic_pkg::OFS_CTRL: begin
          if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) ctrl_q[12:8] <= wb_dat_i[12:8];
        end
        aic_pkg::OFS_FB_CFG: begin
          if (wb_sel_i[0]) fb_mode_q <= wb_dat_i[aic_pkg::FB_MODE_LSB +: 4];
          if (wb_sel_i[2]) fb_dur_q <= dur_wr;
        end
        aic_pkg::OFS_FLUSH_CFG: begin
          if (wb_sel_i[0]) flush_n_q <= wb_dat_i[aic_pkg::FLUSH_N_LSB +: 8];
          if (wb_sel_i[2]) begin
            flush_vol_q <= wb_dat_i[aic_pkg::FLUSH_VOL_LSB +: 16];
          end
        end
        aic_pkg::OFS_SLOW_THR: begin
          if (wb_sel_i[0]) slow_thr_q <= wb_dat_i[15:0];
        end
        aic_pkg::OFS_PUMP_TO: begin
          if (wb_sel_i[0]) pump_to_q <= wb_dat_i[15:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rdat_q <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        aic_pkg::OFS_CTRL: rdat_q <= {19'h00000, ctrl_q};
        aic_pkg::OFS_FB_CFG: rdat_q <= {6'h00, fb_dur_q, 12'h000, fb_mode_q};
        aic_pkg::OFS_FLUSH_CFG: rdat_q <= {flush_vol_q, 8'h00, flush_n_q};
        aic_pkg::OFS_SLOW_THR: rdat_q <= {16'h0000, slow_thr_q};
        aic_pkg::OFS_PUMP_TO: rdat_q <= {16'h0000, pump_to_q};
        aic_pkg::OFS_STATUS: rdat_q <= status;
        default: rdat_q <= 32'h00000000;
      endcase
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // time base and feedback generator
  aic_fb_if fb_if ();
  aic_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .fb_if(fb_if)
  );
  aic_feedback u_fb (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .fb_if(fb_if)
  );
  assign fb_if.mode = fb_mode_q;
  assign fb_if.dur = fb_dur_q;
  assign fb_if.sol = sol_active_i;
  assign fb_if.inj_start = inj_start_i;
  assign fb_if.dose25 = dose25_i;
  assign fb_if.dose50 = dose50_i;
  assign fb_if.dose75 = dose75_i;
  assign fb_if.add_flow = add_flow_i;

  ////////////////////////////////////////////////////////////////////////////
  // permissive and transaction
  logic perm_comb;
  logic alarm_rst;
  logic flush_alm_q;
  logic pump_alm_q;
  logic latched_any;
  logic stop_any;
  logic run_ok;
  logic slow;
  logic clean_en;
  aic_pkg::aic_tx_t tx_q;
  logic clean_tx_q;
  logic [7:0] inj_cnt_q;
  logic [15:0] ws_after_q;

  always_comb begin
    if (ctrl_q[aic_pkg::CTRL_ILK_ASSIGNED]) begin
      perm_comb = ctrl_q[aic_pkg::CTRL_COMB_OR]
                  ? (permissive_i | interlock_i)
                  : (permissive_i & interlock_i);
    end else begin
      perm_comb = permissive_i;
    end
  end

  assign latched_any = flush_alm_q | pump_alm_q;
  // shutdown action halts on latched alarms and tank empty
  assign stop_any = latched_any | tank_empty_i;
  assign run_ok = perm_comb
                  & ~(ctrl_q[aic_pkg::CTRL_ACT_SHUTDOWN] & stop_any);
  assign clean_en = (flush_n_q != 8'h00)
                    & ctrl_q[aic_pkg::CTRL_LOWFLOW_ASSIGNED]
                    & ctrl_q[aic_pkg::CTRL_SMART];

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      tx_q <= aic_pkg::TX_IDLE;
    end else begin
      case (tx_q)
        aic_pkg::TX_IDLE: if (run_ok) tx_q <= aic_pkg::TX_RUN;
        aic_pkg::TX_RUN: if (!run_ok) tx_q <= aic_pkg::TX_END;
        aic_pkg::TX_END: tx_q <= aic_pkg::TX_IDLE;
        default: tx_q <= aic_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clean-arm, slow-flow and flush volume
  logic slow_serial_q;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      slow_serial_q <= 1'b0;
    end else if (cmd[aic_pkg::CMD_SLOW_SET]) begin
      slow_serial_q <= 1'b1;
    end else if (cmd[aic_pkg::CMD_SLOW_CLR] || tx_q == aic_pkg::TX_END) begin
      slow_serial_q <= 1'b0;
    end
  end

  always_comb begin
    case (ctrl_q[aic_pkg::CTRL_SLOW_SRC +: 2])
      aic_pkg::SRC_PULSE: slow = flow_rate_i < slow_thr_q;
      aic_pkg::SRC_DISCRETE: slow = slow_flow_di_i;
      aic_pkg::SRC_SERIAL: slow = slow_serial_q;
      default: slow = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      clean_tx_q <= 1'b0;
      inj_cnt_q <= 8'h00;
      extra_qty_o <= 16'h0000;
      ws_after_q <= 16'h0000;
    end else if (tx_q == aic_pkg::TX_IDLE) begin
      clean_tx_q <= clean_en & run_ok;
      inj_cnt_q <= 8'h00;
      extra_qty_o <= 16'h0000;
      ws_after_q <= 16'h0000;
    end else if (tx_q == aic_pkg::TX_RUN) begin
      if (inj_start_i) begin
        if (clean_tx_q && inj_cnt_q < flush_n_q) begin
          extra_qty_o <= flush_vol_q / {8'h00, flush_n_q};
          inj_cnt_q <= inj_cnt_q + 8'h01;
        end else begin
          extra_qty_o <= 16'h0000;
        end
      end
      if (clean_tx_q && slow && ws_pulse_i && ws_after_q != 16'hffff) begin
        ws_after_q <= ws_after_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarms
  logic [15:0] pump_cnt_q;
  logic pump_wait;
  logic flush_set;
  logic pump_set;

  assign alarm_rst = alarm_reset_i | cmd[aic_pkg::CMD_ALM_RST_SERIAL]
                     | cmd[aic_pkg::CMD_ALM_RST_PANEL];
  assign flush_set = (tx_q == aic_pkg::TX_END) & clean_tx_q
                     & (ws_after_q != flush_vol_q);
  assign pump_wait = ctrl_q[aic_pkg::CTRL_PUMP_FB_ASSIGNED]
                     & pump_demand_i & ~pump_fb_i;
  assign pump_set = pump_wait & (pump_cnt_q >= pump_to_q);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pump_cnt_q <= 16'h0000;
    end else if (!pump_wait) begin
      pump_cnt_q <= 16'h0000;
    end else if (fb_if.tick && pump_cnt_q != 16'hffff) begin
      pump_cnt_q <= pump_cnt_q + 16'h0001;
    end
  end

  // a set in the same cycle as a reset wins
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      flush_alm_q <= 1'b0;
      pump_alm_q <= 1'b0;
    end else begin
      if (flush_set) begin
        flush_alm_q <= 1'b1;
      end else if (alarm_rst) begin
        flush_alm_q <= 1'b0;
      end
      if (pump_set) begin
        pump_alm_q <= 1'b1;
      end else if (alarm_rst) begin
        pump_alm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external solenoid
  logic sol_di_q;
  logic sol_ai_q;
  logic sol_open;
  logic sol_close;
  always_comb begin
    case (ctrl_q[aic_pkg::CTRL_SOL_SRC +: 2])
      aic_pkg::SRC_DISCRETE: begin
        sol_open = sol_di_i & ~sol_di_q;
        sol_close = ~sol_di_i & sol_di_q;
      end
      aic_pkg::SRC_ANALOG: begin
        sol_open = sol_ai_i & ~sol_ai_q;
        sol_close = ~sol_ai_i & sol_ai_q;
      end
      aic_pkg::SRC_SERIAL: begin
        sol_open = cmd[aic_pkg::CMD_SOL_OPEN];
        sol_close = cmd[aic_pkg::CMD_SOL_CLOSE];
      end
      default: begin
        sol_open = 1'b0;
        sol_close = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sol_di_q <= 1'b0;
      sol_ai_q <= 1'b0;
      ext_sol_o <= 1'b0;
    end else begin
      sol_di_q <= sol_di_i;
      sol_ai_q <= sol_ai_i;
      if (!ctrl_q[aic_pkg::CTRL_EXT_SOL] || sol_close) begin
        ext_sol_o <= 1'b0;
      end else if (sol_open) begin
        ext_sol_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      enable_o <= 1'b0;
      inject_hold_o <= 1'b1;
      alarm_ind_o <= 1'b0;
      shutdown_o <= 1'b0;
      block_valve_o <= 1'b0;
      feedback_o <= 1'b0;
    end else begin
      enable_o <= run_ok & ~tank_empty_i;
      inject_hold_o <= ~run_ok | tank_empty_i
                       | (clean_tx_q & slow);
      alarm_ind_o <= latched_any | tank_low_i | tank_empty_i;
      shutdown_o <= ctrl_q[aic_pkg::CTRL_ACT_SHUTDOWN] & stop_any;
      block_valve_o <= ctrl_q[aic_pkg::CTRL_BV_ASSIGNED] & perm_comb;
      feedback_o <= ctrl_q[aic_pkg::CTRL_FB_ASSIGNED] & fb_if.fb;
    end
  end

  always_comb begin
    status = 32'h00000000;
    status[aic_pkg::ST_ENABLED] = enable_o;
    status[aic_pkg::ST_ALARM] = alarm_ind_o;
    status[aic_pkg::ST_FLUSH_ALM] = flush_alm_q;
    status[aic_pkg::ST_PUMP_ALM] = pump_alm_q;
    status[aic_pkg::ST_TANK_LOW] = tank_low_i;
    status[aic_pkg::ST_TANK_EMPTY] = tank_empty_i;
    status[aic_pkg::ST_SLOW] = slow;
    status[aic_pkg::ST_CLEAN_TX] = clean_tx_q;
    status[aic_pkg::ST_EXT_SOL] = ext_sol_o;
    status[aic_pkg::ST_FEEDBACK] = feedback_o;
    status[aic_pkg::ST_HOLD] = inject_hold_o;
    status[aic_pkg::ST_EXTRA_LSB +: 16] = extra_qty_o;
  end
endmodule
`default_nettype wire

// >>> logic/aic_pkg.sv
/*
 * aic_pkg: register map, field positions, reset values, feedback mode codes
 * and timing constants of the additive injector i/o control block.
 * assumes: included in compile order before every other design file.
 */
`default_nettype none
package aic_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_FB_CFG = 8'h08;
  localparam logic [7:0] OFS_FLUSH_CFG = 8'h0c;
  localparam logic [7:0] OFS_SLOW_THR = 8'h10;
  localparam logic [7:0] OFS_PUMP_TO = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ctrl fields
  localparam int CTRL_ILK_ASSIGNED = 0;
  localparam int CTRL_COMB_OR = 1;
  localparam int CTRL_SMART = 2;
  localparam int CTRL_LOWFLOW_ASSIGNED = 3;
  localparam int CTRL_PUMP_FB_ASSIGNED = 4;
  localparam int CTRL_BV_ASSIGNED = 5;
  localparam int CTRL_FB_ASSIGNED = 6;
  localparam int CTRL_ACT_SHUTDOWN = 7;
  localparam int CTRL_SLOW_SRC = 8;
  localparam int CTRL_EXT_SOL = 10;
  localparam int CTRL_SOL_SRC = 11;
  localparam logic [12:0] CTRL_RESET = 13'h0000;
  // slow-flow and solenoid sources
  localparam logic [1:0] SRC_PULSE = 2'h0;
  localparam logic [1:0] SRC_DISCRETE = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] SRC_ANALOG = 2'h3;
  // cmd fields, write-one pulses
  localparam int CMD_ALM_RST_SERIAL = 0;
  localparam int CMD_ALM_RST_PANEL = 1;
  localparam int CMD_SLOW_SET = 2;
  localparam int CMD_SLOW_CLR = 3;
  localparam int CMD_SOL_OPEN = 4;
  localparam int CMD_SOL_CLOSE = 5;
  // feedback config fields
  localparam int FB_MODE_LSB = 0;
  localparam int FB_DUR_LSB = 16;
  localparam logic [9:0] FB_DUR_RESET = 10'h1f4;
  localparam logic [9:0] FB_DUR_MAX = 10'h3e8;
  // flush config fields, slow-flow threshold and pump timeout resets
  localparam int FLUSH_N_LSB = 0;
  localparam int FLUSH_VOL_LSB = 16;
  localparam logic [15:0] SLOW_THR_RESET = 16'h0000;
  localparam logic [15:0] PUMP_TO_RESET = 16'h03e8;
  // status fields
  localparam int ST_ENABLED = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_FLUSH_ALM = 2;
  localparam int ST_PUMP_ALM = 3;
  localparam int ST_TANK_LOW = 4;
  localparam int ST_TANK_EMPTY = 5;
  localparam int ST_SLOW = 6;
  localparam int ST_CLEAN_TX = 7;
  localparam int ST_EXT_SOL = 8;
  localparam int ST_FEEDBACK = 9;
  localparam int ST_HOLD = 10;
  localparam int ST_EXTRA_LSB = 16;
  // feedback mode codes
  localparam logic [3:0] FBM_NONE = 4'h0;
  localparam logic [3:0] FBM_END = 4'h1;
  localparam logic [3:0] FBM_END_INV = 4'h2;
  localparam logic [3:0] FBM_MID = 4'h3;
  localparam logic [3:0] FBM_PISTON = 4'h4;
  localparam logic [3:0] FBM_PISTON_INV = 4'h5;
  localparam logic [3:0] FBM_POST = 4'h6;
  localparam logic [3:0] FBM_DOUBLE = 4'h7;
  localparam logic [3:0] FBM_LAST = 4'h8;
  localparam logic [3:0] FBM_EXT = 4'h9;
  localparam logic [3:0] FBM_EXT_INV = 4'ha;
  // transaction states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_RUN = 3'b010,
    TX_END = 3'b100
  } aic_tx_t;
endpackage
`default_nettype wire

// >>> logic/aic_fb_if.sv
/*
 * aic_fb_if: carries the millisecond tick and the injection events from the
 * control top to the feedback generator, and the feedback level back.
 * assumes: one clock domain; all signals synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
interface aic_fb_if;
  logic tick;
  logic [3:0] mode;
  logic [9:0] dur;
  logic sol;
  logic inj_start;
  logic dose25;
  logic dose50;
  logic dose75;
  logic add_flow;
  logic fb;
  modport ctl (input tick, input fb, output mode, output dur, output sol,
    output inj_start, output dose25, output dose50, output dose75,
    output add_flow);
  modport ticker (output tick);
  modport gen (input tick, input mode, input dur, input sol,
    input inj_start, input dose25, input dose50, input dose75,
    input add_flow, output fb);
endinterface
`default_nettype wire

// >>> logic/aic_tick.sv
/*
 * aic_tick: one-cycle pulse every CYCLES clocks, the millisecond time base.
 * assumes: ref_clk_i free running; nrst_i synchronous active low.
 */
`timescale 1ns/1ps
`default_nettype none
module aic_tick #(
  parameter int unsigned CYCLES = aic_pkg::TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  aic_fb_if.ticker fb_if
);
  if (CYCLES < 2 || CYCLES > 32'h00ffffff) begin : g_chk
    $error("aic_tick: CYCLES out of range");
  end
  logic [23:0] cnt_q;
  logic tick_q;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (cnt_q == 24'(CYCLES - 1)) begin
      cnt_q <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end
  assign fb_if.tick = tick_q;
endmodule
`default_nettype wire

// >>> logic/aic_feedback.sv
/*
 * aic_feedback: injector feedback output in all feedback modes.
 * assumes: events are one-cycle pulses, sol is a level, tick is 1 ms.
 */
`timescale 1ns/1ps
`default_nettype none
module aic_feedback (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  aic_fb_if.gen fb_if
);
  logic [9:0] pulse_q;
  logic [9:0] ext_q;
  logic sol_q;
  logic tog_q;
  logic flow_seen_q;
  logic dose_seen_q;
  logic toggled_q;
  logic fb_q;
  logic fire;
  logic sol_fall;
  assign sol_fall = sol_q & ~fb_if.sol;
  always_comb begin
    fire = 1'b0;
    case (fb_if.mode)
      aic_pkg::FBM_POST: fire = sol_fall;
      aic_pkg::FBM_DOUBLE: fire = fb_if.dose25 | fb_if.dose75;
      aic_pkg::FBM_LAST: fire = fb_if.dose75;
      aic_pkg::FBM_MID: fire = fb_if.dose50;
      default: fire = 1'b0;
    endcase
  end
  // fixed-length pulse, counted in milliseconds
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pulse_q <= 10'h000;
    end else if (fire) begin
      pulse_q <= fb_if.dur;
    end else if (fb_if.tick && pulse_q != 10'h000) begin
      pulse_q <= pulse_q - 10'h001;
    end
  end
  // extension after the solenoid closes
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ext_q <= 10'h000;
      sol_q <= 1'b0;
    end else begin
      sol_q <= fb_if.sol;
      if (fb_if.sol) begin
        ext_q <= 10'h000;
      end else if (sol_fall) begin
        ext_q <= fb_if.dur;
      end else if (fb_if.tick && ext_q != 10'h000) begin
        ext_q <= ext_q - 10'h001;
      end
    end
  end
  // end-sensor emulation: one toggle per injection after flow and 25 %
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      tog_q <= 1'b0;
      flow_seen_q <= 1'b0;
      dose_seen_q <= 1'b0;
      toggled_q <= 1'b0;
    end else if (fb_if.inj_start) begin
      flow_seen_q <= fb_if.add_flow;
      dose_seen_q <= fb_if.dose25;
      toggled_q <= 1'b0;
    end else begin
      if (fb_if.add_flow) begin
        flow_seen_q <= 1'b1;
      end
      if (fb_if.dose25) begin
        dose_seen_q <= 1'b1;
      end
      if (!toggled_q && (flow_seen_q || fb_if.add_flow)
          && (dose_seen_q || fb_if.dose25)) begin
        tog_q <= ~tog_q;
        toggled_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      fb_q <= 1'b0;
    end else begin
      case (fb_if.mode)
        aic_pkg::FBM_PISTON: fb_q <= fb_if.sol;
        aic_pkg::FBM_PISTON_INV: fb_q <= ~fb_if.sol;
        aic_pkg::FBM_EXT: fb_q <= fb_if.sol | (ext_q != 10'h000);
        aic_pkg::FBM_EXT_INV: fb_q <= ~(fb_if.sol | (ext_q != 10'h000));
        aic_pkg::FBM_END: fb_q <= tog_q;
        aic_pkg::FBM_END_INV: fb_q <= ~tog_q;
        aic_pkg::FBM_POST, aic_pkg::FBM_DOUBLE, aic_pkg::FBM_LAST,
        aic_pkg::FBM_MID: fb_q <= fire | (pulse_q != 10'h000);
        default: fb_q <= 1'b0;
      endcase
    end
  end
  assign fb_if.fb = fb_q;
endmodule
`default_nettype wire

// >>> tb/aic_io_ctrl_properties.sv
/* aic_io_ctrl_chk: port-level properties of the i/o control top.
   assumes: bound to aic_io_ctrl; one clock, sync active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module aic_io_ctrl_chk (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic permissive_i,
  input wire logic interlock_i,
  input wire logic tank_low_i,
  input wire logic tank_empty_i,
  input wire logic enable_o,
  input wire logic alarm_ind_o,
  input wire logic shutdown_o,
  input wire logic block_valve_o,
  input wire logic feedback_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  perm_off_a: assert property (!permissive_i && !interlock_i
    |=> !enable_o)
    else $error("enabled without permissive");
  empty_block_a: assert property (tank_empty_i |=> !enable_o)
    else $error("enabled with tank empty");
  valve_off_a: assert property (!permissive_i && !interlock_i
    |=> !block_valve_o)
    else $error("valve on without permissive");
  low_alarm_a: assert property (tank_low_i |=> alarm_ind_o)
    else $error("tank low not indicated");
  shut_ind_a: assert property (shutdown_o |-> alarm_ind_o)
    else $error("shutdown without indication");
  cover property ($rose(enable_o));
  cover property ($rose(shutdown_o));
  cover property ($rose(feedback_o));
endmodule
bind aic_io_ctrl aic_io_ctrl_chk aic_io_ctrl_chk_i (.*);
`default_nettype wire

// >>> tb/aic_field_model.sv
/* aic_field_model: wild stream pulses, slow-flow switch, solenoid line.
   assumes: run_i high while the stream flows. */
`timescale 1ns/1ps
`default_nettype none
module aic_field_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic sol_cmd_i,
  output logic ws_pulse_o,
  output logic slow_o,
  output logic sol_o
);
  logic [5:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) cnt_q <= 6'h0;
    else if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h1;
  end
  assign ws_pulse_o = run_i && (cnt_q[1:0] == 2'h3);
  assign slow_o = run_i && cnt_q[5];
  always_ff @(posedge clk_i) sol_o <= nrst_i && sol_cmd_i;
endmodule
`default_nettype wire

// >>> tb/tb_aic_io_ctrl.sv
/* tb_aic_io_ctrl: self-checking bench of the i/o control top.
   assumes: short tick parameter; field model on the far side. */
`timescale 1ns/1ps
`default_nettype none
module tb_aic_io_ctrl;
  logic ref_clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sol_cmd;
  logic permissive_i, interlock_i, alarm_reset_i, pump_demand_i, pump_fb_i;
  logic tank_low_i, tank_empty_i, slow_flow_di_i, ws_pulse_i, sol_di_i;
  logic sol_ai_i, inj_start_i, sol_active_i, dose25_i, dose50_i, dose75_i;
  logic add_flow_i, enable_o, inject_hold_o, ext_sol_o, alarm_ind_o;
  logic shutdown_o, block_valve_o, feedback_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] flow_rate_i, extra_qty_o;
  int num_errors, checks, seed, i;
  aic_io_ctrl #(.TICK_CYCLES(8)) aic_io_ctrl_i (.*);
  aic_field_model aic_field_model_i (.clk_i(ref_clk_i), .nrst_i(nrst_i),
    .run_i(permissive_i), .sol_cmd_i(sol_cmd), .ws_pulse_o(ws_pulse_i),
    .slow_o(slow_flow_di_i), .sol_o(sol_di_i));
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) {inj_start_i, dose25_i, dose50_i, dose75_i,
    add_flow_i, sol_ai_i, flow_rate_i} <= 22'($random(seed));
  function automatic logic exp_en(input logic [3:0] c);
    return !c[0] ? c[2] : (c[1] ? (c[2] | c[3]) : (c[2] & c[3]));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    if (!w) rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge ref_clk_i);
  endtask
  task automatic complete_run;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    complete_run;
  end
  initial begin
    ref_clk_i = 1'b0;
    nrst_i = 1'b0;
    seed = 32'h6a6ff358;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, sol_cmd} <= '0;
    {permissive_i, interlock_i, alarm_reset_i, pump_demand_i} <= '0;
    {pump_fb_i, tank_low_i, tank_empty_i, sol_active_i} <= '0;
    wb_sel_i <= 4'hf;
    wait_n(10);
    nrst_i <= 1'b1;
    wait_n(1);
    bus(0, aic_pkg::OFS_FB_CFG, 0);
    chk(rd, 32'h01f40000);
    bus(1, aic_pkg::OFS_FB_CFG, 32'h03ff0004);
    bus(0, aic_pkg::OFS_FB_CFG, 0);
    chk(rd, 32'h03e80004);
    bus(0, 8'h1c, 0);
    chk(rd, 0);
    $display("registers done");
    for (i = 0; i < 24; i++) begin
      rd = $random(seed);
      bus(1, aic_pkg::OFS_CTRL, {26'h0, 1'b1, 3'h0, rd[1:0]});
      {permissive_i, interlock_i} <= {rd[2], rd[3]};
      wait_n(3);
      chk(enable_o, exp_en(rd[3:0]));
      chk(block_valve_o, exp_en(rd[3:0]));
    end
    $display("permissive done");
    bus(1, aic_pkg::OFS_CTRL, 32'h20);
    {permissive_i, tank_empty_i} <= 2'b11;
    wait_n(3);
    chk({enable_o, inject_hold_o, extra_qty_o}, 18'h10000);
    {tank_empty_i, tank_low_i} <= 2'b01;
    wait_n(3);
    chk({enable_o, alarm_ind_o, shutdown_o}, 3'b110);
    tank_low_i <= 1'b0;
    wait_n(3);
    chk(alarm_ind_o, 0);
    $display("tank done");
    bus(1, aic_pkg::OFS_CTRL, 32'h90);
    bus(1, aic_pkg::OFS_PUMP_TO, 32'h2);
    {pump_demand_i, pump_fb_i} <= 2'b11;
    wait_n(40);
    chk(alarm_ind_o, 0);
    for (i = 0; i < 3; i++) begin
      {pump_demand_i, pump_fb_i} <= 2'b10;
      wait_n(40);
      chk({alarm_ind_o, shutdown_o}, 2'b11);
      pump_demand_i <= 1'b0;
      alarm_reset_i <= (i == 0);
      wait_n(2);
      alarm_reset_i <= 1'b0;
      if (i > 0) bus(1, aic_pkg::OFS_CMD, i);
      wait_n(3);
      chk({alarm_ind_o, shutdown_o}, 2'b00);
    end
    $display("alarms done");
    bus(1, aic_pkg::OFS_CTRL, 32'h40);
    for (i = 4; i < 7; i++) begin
      bus(1, aic_pkg::OFS_FB_CFG, 32'h01f40000 | i);
      sol_active_i <= 1'b1;
      wait_n(4);
      chk(feedback_o, i == 4);
      sol_active_i <= 1'b0;
      wait_n(4);
      chk(feedback_o, i != 4);
    end
    bus(1, aic_pkg::OFS_CTRL, 32'h0c00);
    sol_cmd <= 1'b1;
    wait_n(4);
    chk(ext_sol_o, 1);
    sol_cmd <= 1'b0;
    wait_n(4);
    chk(ext_sol_o, 0);
    bus(1, aic_pkg::OFS_CTRL, 32'h1400);
    bus(1, aic_pkg::OFS_CMD, 32'h10);
    chk(ext_sol_o, 1);
    bus(1, aic_pkg::OFS_CMD, 32'h20);
    chk(ext_sol_o, 0);
    $display("outputs done");
    complete_run;
  end
endmodule
`default_nettype wire
